// >>> src/uab_defines.svh
`ifndef UAB_DEFINES_SVH
`define UAB_DEFINES_SVH
// Contract
// - baud generator mode: aux timer counts every state time or count pin.
// - externally clocked: bit rate is aux overflow rate over 16.
// - internally clocked: bit rate is osc/(32*(65536-reload)).
// - internal control: reload only on overflow; capture mode never captures.
// - external control: trigger falling edge also captures/reloads, not baud.
// - mode 0: 8 bits LSB first on data pin, clock out, osc/12.
// - mode 1: start 0, 8 data bits LSB first, stop 1.
// - mode 1 receive: stop bit lands in rx ninth bit.
// - mode 2: 11 bits, ninth from tx ninth bit, osc/32 or osc/64.
// - mode 2 receive: ninth bit into rx ninth bit, stop ignored.
// - mode 3 equals mode 2 apart from variable bit rate.
// - a write to the serial buffer queues a frame for transmission; it is dropped while the fifo is full.
// - mode 0 reception starts when rx done is 0 and enable is 1; the code also waits for tx idle and no byte queued.
// - modes 1-3 reception starts on a start bit if enabled.
// - serial control holds mode bits, ninth bits and done flags.
// - modes 1 and 3: tx/rx bit clock from aux overflow when its select is 1.
// - baud mode rollover reloads without setting overflow flag.

// register addresses on the special function register port
`define UAB_A_SCTL 8'h00
`define UAB_A_SERIAL_BUFFER 8'h01
`define UAB_A_ACTL 8'h02
`define UAB_A_RLL 8'h03
`define UAB_A_RLH 8'h04
`define UAB_A_CNTL 8'h05
`define UAB_A_CNTH 8'h06

`define UAB_SCTL_RESET 8'h00
`define UAB_ACTL_RESET 8'h00
`define UAB_NINTH_POS 8

// oscillator clocks per machine cycle is 12; per state time is 2
`define UAB_DIV_LAST 4'hB
`define UAB_M0_CLK_HIGH 4'h6
// 16 samples per bit in the asynchronous modes
`define UAB_SUB_LAST 4'hF
`define UAB_SUB_MID 4'h7
`define UAB_TX_LAST_M0 4'h7
`define UAB_TX_LAST_M1 4'h9
`define UAB_TX_LAST_M2 4'hA
`define UAB_RX_LAST_M0 4'h7
`define UAB_RX_LAST 4'h8
`define UAB_CNT_MAX 16'hFFFF
`endif

// >>> src/uab_pkg.sv
package uab_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} uab_sfr_req_t;

	typedef struct packed {
		logic mode_sel_hi;
		logic mode_sel_lo;
		logic multiproc_enable;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
	} uab_serial_control_t;

	typedef struct packed {
		logic aux_overflow_flag;
		logic aux_external_flag;
		logic rx_baud_select;
		logic tx_baud_select;
		logic aux_trigger_enable;
		logic aux_run_bit;
		logic count_select;
		logic capture_select;
	} uab_actl_t;

	typedef enum logic [1:0] {
		UAB_MODE_SHIFT, UAB_MODE_8BIT, UAB_MODE_9BIT_FIX, UAB_MODE_9BIT_VAR
	} uab_mode_t;
	typedef enum logic {UAB_TX_IDLE, UAB_TX_SEND} uab_tx_st_t;
	typedef enum logic [1:0] {UAB_RX_IDLE, UAB_RX_START, UAB_RX_DATA} uab_rx_st_t;

	typedef struct packed {
		uab_serial_control_t serial_control;
		uab_actl_t actl;
		logic [15:0] count;
		logic [15:0] reload;
		logic [7:0] rx_buf;
		logic [7:0] rdata;
		logic [3:0] div;
		logic half_m2;
		logic half_t1;
		logic [2:0] rxd_sy;
		logic [2:0] cpin_sy;
		logic [2:0] trig_sy;
		uab_tx_st_t tx_st;
		logic [10:0] tx_shift;
		logic [3:0] tx_bits;
		logic [3:0] tx_sub;
		logic txd;
		logic rxd_out;
		logic rxd_oe;
		uab_rx_st_t rx_st;
		logic [8:0] rx_shift;
		logic [3:0] rx_bits;
		logic [3:0] rx_sub;
	} uab_state_t;
endpackage

// >>> src/uab_fifo.sv
`timescale 1ns/100ps
module uab_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
			$error("fifo depth must be a power of two, at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [W-1:0] dout;
		logic ovalid;
	} uab_fifo_st_t;

	uab_fifo_st_t st;
	uab_fifo_st_t next_st;
	logic push;
	logic pop;

	assign in_ready = st.cnt < (AW+1)'(DEPTH);
	assign out_valid = st.ovalid;
	assign out_data = st.dout;
	assign push = in_valid && in_ready;
	// output register refills whenever it is empty or being taken
	assign pop = (!st.ovalid || out_ready) && st.cnt != '0;

	always_comb begin
		next_st = st;
		if (out_ready)
			next_st.ovalid = 1'b0;
		if (pop) begin
			next_st.dout = st.mem[st.rp];
			next_st.ovalid = 1'b1;
			next_st.rp = st.rp + 1'b1;
		end
		if (push) begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = st.wp + 1'b1;
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

// >>> src/uab_serial_port.sv
`timescale 1ns/100ps
`include "uab_defines.svh"
module uab_serial_port import uab_pkg::*; #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire uab_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	output logic tx_buffer_ready,
	input wire logic timer1_ovf,
	input wire logic smod,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd,
	input wire logic aux_count_pin,
	input wire logic aux_trigger_pin,
	output logic serial_irq,
	output logic aux_irq
);
	generate
		if (FIFO_DEPTH < 2) begin : g_bad
			$error("transmit fifo needs at least two words");
		end
	endgenerate

	uab_state_t st;
	uab_state_t next_st;
	uab_mode_t mode;
	logic [8:0] fifo_out_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic push;
	logic wr_sctl, wr_actl, wr_rll, wr_rlh, wr_cl, wr_ch;
	logic baud, state_en, mach_en, cpin_fall, trig_fall, rxd_fall;
	logic inc, aux_ovf, m2_tick, t1_tick, tx_tick, rx_tick;
	logic rxd, tx_step, rx_step, m0_act;

	assign mode = uab_mode_t'({st.serial_control.mode_sel_hi, st.serial_control.mode_sel_lo});
	assign wr_sctl = sfr_req.wr && sfr_req.addr == `UAB_A_SCTL;
	assign wr_actl = sfr_req.wr && sfr_req.addr == `UAB_A_ACTL;
	assign wr_rll = sfr_req.wr && sfr_req.addr == `UAB_A_RLL;
	assign wr_rlh = sfr_req.wr && sfr_req.addr == `UAB_A_RLH;
	assign wr_cl = sfr_req.wr && sfr_req.addr == `UAB_A_CNTL;
	assign wr_ch = sfr_req.wr && sfr_req.addr == `UAB_A_CNTH;
	assign push = sfr_req.wr && sfr_req.addr == `UAB_A_SERIAL_BUFFER;

	// synchronised pins; edges compare second and third stages only
	assign rxd = st.rxd_sy[1];
	assign rxd_fall = st.rxd_sy[2] && !st.rxd_sy[1];
	assign cpin_fall = st.cpin_sy[2] && !st.cpin_sy[1];
	assign trig_fall = st.actl.aux_trigger_enable
		&& st.trig_sy[2] && !st.trig_sy[1];

	assign state_en = st.div[0];
	assign mach_en = st.div == `UAB_DIV_LAST;
	assign baud = st.actl.rx_baud_select || st.actl.tx_baud_select;
	// state time in baud mode instead of machine cycle
	assign inc = st.actl.aux_run_bit && (st.actl.count_select ? cpin_fall
		: (baud ? state_en : mach_en));
	assign aux_ovf = inc && st.count == `UAB_CNT_MAX;
	assign m2_tick = state_en && (smod || st.half_m2);
	assign t1_tick = timer1_ovf && (smod || st.half_t1);
	// aux overflow is one sample of sixteen: rate/16 per bit
	assign tx_tick = mode == UAB_MODE_9BIT_FIX ? m2_tick
		: (st.actl.tx_baud_select ? aux_ovf : t1_tick);
	assign rx_tick = mode == UAB_MODE_9BIT_FIX ? m2_tick
		: (st.actl.rx_baud_select ? aux_ovf : t1_tick);
	assign tx_step = mode == UAB_MODE_SHIFT ? mach_en
		: tx_tick && st.tx_sub == `UAB_SUB_LAST;
	assign rx_step = mode == UAB_MODE_SHIFT ? mach_en
		: rx_tick && st.rx_sub == `UAB_SUB_LAST;
	// mode 0 frames start on a machine cycle boundary so that the
	// first shift clock is a whole one and no bit slips past the pin
	assign fifo_out_ready = st.tx_st == UAB_TX_IDLE
		&& (mode != UAB_MODE_SHIFT || mach_en);

	uab_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clock(clock),
		.rst_b(rst_b),
		.in_valid(push),
		.in_ready(tx_buffer_ready),
		.in_data({st.serial_control.tx_ninth_bit, sfr_req.wdata}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_comb begin
		next_st = st;
		next_st.rxd_sy = {st.rxd_sy[1:0], rxd_in};
		next_st.cpin_sy = {st.cpin_sy[1:0], aux_count_pin};
		next_st.trig_sy = {st.trig_sy[1:0], aux_trigger_pin};
		next_st.div = mach_en ? 4'h0 : st.div + 4'h1;
		if (state_en)
			next_st.half_m2 = !st.half_m2;
		if (timer1_ovf)
			next_st.half_t1 = !st.half_t1;

		// software writes first so that hardware sets win over clears
		if (wr_sctl)
			next_st.serial_control = uab_serial_control_t'(sfr_req.wdata);
		if (wr_actl)
			next_st.actl = uab_actl_t'(sfr_req.wdata);

		if (inc)
			next_st.count = st.count + 16'h0001;
		if (aux_ovf) begin
			if (baud || !st.actl.capture_select)
				next_st.count = st.reload;
			if (!baud)
				next_st.actl.aux_overflow_flag = 1'b1;
		end
		if (trig_fall) begin
			next_st.actl.aux_external_flag = 1'b1;
			if (!baud && st.actl.capture_select)
				next_st.reload = st.count;
			else if (!baud)
				next_st.count = st.reload;
		end
		// a write racing a reload is the software's hazard
		if (wr_rll)
			next_st.reload[7:0] = sfr_req.wdata;
		if (wr_rlh)
			next_st.reload[15:8] = sfr_req.wdata;
		if (wr_cl)
			next_st.count[7:0] = sfr_req.wdata;
		if (wr_ch)
			next_st.count[15:8] = sfr_req.wdata;

		case (st.tx_st)
			UAB_TX_IDLE: begin
				if (fifo_out_valid && fifo_out_ready) begin
					next_st.tx_st = UAB_TX_SEND;
					next_st.tx_sub = 4'h0;
					next_st.tx_bits = 4'h0;
					if (mode == UAB_MODE_SHIFT)
						next_st.tx_shift = {3'b111, fifo_out_data[7:0]};
					else if (mode == UAB_MODE_8BIT)
						next_st.tx_shift = {2'b11, fifo_out_data[7:0], 1'b0};
					else
						next_st.tx_shift = {1'b1,
							fifo_out_data[`UAB_NINTH_POS],
							fifo_out_data[7:0], 1'b0};
				end
			end
			UAB_TX_SEND: begin
				if (tx_tick && mode != UAB_MODE_SHIFT)
					next_st.tx_sub = st.tx_sub + 4'h1;
				if (tx_step) begin
					next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
					next_st.tx_bits = st.tx_bits + 4'h1;
					if (st.tx_bits == (mode == UAB_MODE_SHIFT ? `UAB_TX_LAST_M0
						: mode == UAB_MODE_8BIT ? `UAB_TX_LAST_M1
						: `UAB_TX_LAST_M2)) begin
						next_st.tx_st = UAB_TX_IDLE;
						next_st.serial_control.tx_done_flag = 1'b1;
					end
				end
			end
			default: next_st.tx_st = UAB_TX_IDLE;
		endcase

		case (st.rx_st)
			UAB_RX_IDLE: begin
				next_st.rx_sub = 4'h0;
				next_st.rx_bits = 4'h0;
				if (st.serial_control.rx_enable && mode == UAB_MODE_SHIFT) begin
					// shared pins: no reception while a byte waits to go
					if (!st.serial_control.rx_done_flag && st.tx_st == UAB_TX_IDLE
						&& !fifo_out_valid && mach_en)
						next_st.rx_st = UAB_RX_DATA;
				end else if (st.serial_control.rx_enable && rxd_fall)
					next_st.rx_st = UAB_RX_START;
			end
			UAB_RX_START: begin
				if (rx_tick) begin
					next_st.rx_sub = st.rx_sub + 4'h1;
					// false start if the line is back high at mid-bit
					if (st.rx_sub == `UAB_SUB_MID) begin
						next_st.rx_sub = 4'h0;
						next_st.rx_st = rxd ? UAB_RX_IDLE : UAB_RX_DATA;
					end
				end
			end
			UAB_RX_DATA: begin
				if (rx_tick && mode != UAB_MODE_SHIFT)
					next_st.rx_sub = st.rx_sub + 4'h1;
				if (rx_step) begin
					next_st.rx_shift = {rxd, st.rx_shift[8:1]};
					next_st.rx_bits = st.rx_bits + 4'h1;
					if (mode == UAB_MODE_SHIFT
						&& st.rx_bits == `UAB_RX_LAST_M0) begin
						next_st.rx_buf = {rxd, st.rx_shift[8:2]};
						next_st.serial_control.rx_done_flag = 1'b1;
						next_st.rx_st = UAB_RX_IDLE;
					end else if (mode != UAB_MODE_SHIFT
						&& st.rx_bits == `UAB_RX_LAST) begin
						// ninth sample: stop bit in mode 1, ninth bit else
						next_st.rx_buf = st.rx_shift[8:1];
						next_st.serial_control.rx_ninth_bit = rxd;
						next_st.serial_control.rx_done_flag = 1'b1;
						next_st.rx_st = UAB_RX_IDLE;
					end
				end
			end
			default: next_st.rx_st = UAB_RX_IDLE;
		endcase

		m0_act = mode == UAB_MODE_SHIFT && (next_st.tx_st == UAB_TX_SEND
			|| next_st.rx_st == UAB_RX_DATA);
		if (mode == UAB_MODE_SHIFT)
			next_st.txd = !m0_act || next_st.div >= `UAB_M0_CLK_HIGH;
		else
			next_st.txd = next_st.tx_st == UAB_TX_IDLE
				|| next_st.tx_shift[0];
		next_st.rxd_oe = mode == UAB_MODE_SHIFT
			&& next_st.tx_st == UAB_TX_SEND;
		next_st.rxd_out = next_st.tx_shift[0];

		if (sfr_req.rd) begin
			case (sfr_req.addr)
				`UAB_A_SCTL: next_st.rdata = st.serial_control;
				`UAB_A_SERIAL_BUFFER: next_st.rdata = st.rx_buf;
				`UAB_A_ACTL: next_st.rdata = st.actl;
				`UAB_A_RLL: next_st.rdata = st.reload[7:0];
				`UAB_A_RLH: next_st.rdata = st.reload[15:8];
				`UAB_A_CNTL: next_st.rdata = st.count[7:0];
				`UAB_A_CNTH: next_st.rdata = st.count[15:8];
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.serial_control <= `UAB_SCTL_RESET;
			st.actl <= `UAB_ACTL_RESET;
			st.txd <= 1'b1;
			st.rxd_out <= 1'b1;
			st.rxd_sy <= 3'h7;
			st.cpin_sy <= 3'h7;
			st.trig_sy <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	assign sfr_rdata = st.rdata;
	assign txd = st.txd;
	assign rxd_out = st.rxd_out;
	assign rxd_oe = st.rxd_oe;
	assign serial_irq = st.serial_control.tx_done_flag || st.serial_control.rx_done_flag;
	assign aux_irq = st.actl.aux_overflow_flag
		|| st.actl.aux_external_flag;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_aux_inc;
		st.actl.aux_run_bit && baud && !st.actl.count_select && state_en
		&& st.count != `UAB_CNT_MAX && !wr_cl && !wr_ch
		|=> st.count == $past(st.count) + 16'h0001;
	endproperty
	a_aux_inc: assert property (p_aux_inc)
		else $error("aux timer missed a state-time step");

	property p_baud_ovf;
		baud && aux_ovf && !st.actl.aux_overflow_flag && !wr_actl
		&& !wr_cl && !wr_ch
		|=> !st.actl.aux_overflow_flag && st.count == $past(st.reload);
	endproperty
	a_baud_ovf: assert property (p_baud_ovf)
		else $error("baud rollover set flag or skipped reload");

	property p_tx_bit;
		st.tx_st == UAB_TX_SEND && mode != UAB_MODE_SHIFT && tx_step
		|=> st.txd == $past(st.tx_shift[1]);
	endproperty
	a_tx_bit: assert property (p_tx_bit)
		else $error("tx bit did not advance after 16 samples");

	property p_m1_frame;
		st.tx_st == UAB_TX_IDLE && fifo_out_valid && mode == UAB_MODE_8BIT
		|=> !st.txd && st.tx_shift[9] && st.tx_st == UAB_TX_SEND;
	endproperty
	a_m1_frame: assert property (p_m1_frame)
		else $error("mode 1 frame lacks start or stop bit");

	property p_m2_ninth;
		st.tx_st == UAB_TX_IDLE && fifo_out_valid && mode[1]
		|=> st.tx_shift[9] == $past(fifo_out_data[8]) && st.tx_shift[10];
	endproperty
	a_m2_ninth: assert property (p_m2_ninth)
		else $error("ninth tx bit not taken from buffer");

	property p_m2_ninth_rx;
		st.rx_st == UAB_RX_DATA && mode[1] && rx_step
		&& st.rx_bits == `UAB_RX_LAST && !wr_sctl
		|=> st.serial_control.rx_ninth_bit == $past(rxd)
		&& st.rx_buf == $past(st.rx_shift[8:1]);
	endproperty
	a_m2_ninth_rx: assert property (p_m2_ninth_rx)
		else $error("mode 2 ninth bit not stored on receive");

	property p_done_flag;
		st.tx_st == UAB_TX_SEND ##1 st.tx_st == UAB_TX_IDLE
		|-> st.serial_control.tx_done_flag && serial_irq;
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("tx done flag not set at frame end");

	property p_m0_rx;
		mode == UAB_MODE_SHIFT && st.rx_st == UAB_RX_IDLE && !wr_sctl
		&& st.serial_control.rx_enable && !st.serial_control.rx_done_flag
		&& st.tx_st == UAB_TX_IDLE && !fifo_out_valid && mach_en
		|=> (st.rx_st == UAB_RX_DATA && !st.txd) [*6];
	endproperty
	a_m0_rx: assert property (p_m0_rx)
		else $error("mode 0 reception did not start");

	property p_async_rx;
		mode != UAB_MODE_SHIFT && st.rx_st == UAB_RX_IDLE && rxd_fall
		&& st.serial_control.rx_enable && !wr_sctl |=> st.rx_st == UAB_RX_START;
	endproperty
	a_async_rx: assert property (p_async_rx)
		else $error("start bit ignored");

	property p_m1_stop;
		st.rx_st == UAB_RX_DATA && mode == UAB_MODE_8BIT && rx_step
		&& st.rx_bits == `UAB_RX_LAST && !wr_sctl
		|=> st.serial_control.rx_ninth_bit == $past(rxd) && st.serial_control.rx_done_flag;
	endproperty
	a_m1_stop: assert property (p_m1_stop)
		else $error("stop bit not stored in rx ninth bit");

	property p_m0_drive;
		mode == UAB_MODE_SHIFT && st.tx_st == UAB_TX_SEND && !wr_sctl
		&& !tx_step
		|=> rxd_oe;
	endproperty
	a_m0_drive: assert property (p_m0_drive)
		else $error("mode 0 data pin not driven during send");
endmodule

// >>> verification/uab_remote.sv
`timescale 1ns/100ps
module uab_remote (
	input wire logic clock,
	input wire logic m0,
	input wire logic [15:0] bit_clks,
	input wire logic [3:0] nbits,
	input wire logic txd,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	output logic rxd_in
);
	logic [10:0] got_q[$];
	logic [10:0] w;
	logic [7:0] m0_in;
	logic [7:0] m0_out;
	int gap;
	int m0_bad;
	initial begin
		rxd_in = 1'b1;
		gap = 0;
		m0_bad = 0;
	end
	// mid-bit sampling; a dip shorter than half a bit is no frame
	always begin
		@(negedge txd);
		if (!m0) begin
			w = '0;
			repeat (bit_clks / 2) @(posedge clock);
			if (txd === 1'b0) begin
				for (int i = 0; i < nbits; i++) begin
					repeat (bit_clks) @(posedge clock);
					w[i] = txd;
				end
				got_q.push_back(w);
			end
		end
	end
	always @(posedge clock) gap <= gap + 1;
	always @(posedge txd) begin
		if (m0 && rxd_oe === 1'b1) begin
			m0_in = {rxd_out, m0_in[7:1]};
			if (gap != 12 && gap < 24) m0_bad++;
			gap = 0;
		end
	end
	// shift clock falls: put the next bit on the data pin
	always @(negedge txd) begin
		if (m0 && rxd_oe !== 1'b1) begin
			#1 rxd_in = m0_out[0];
			m0_out = m0_out >> 1;
		end
	end
	// line has a pull-up once released
	always @(negedge m0) rxd_in = 1'b1;
	task automatic send(logic [10:0] f, logic [3:0] nb, logic [15:0] clks);
		@(posedge clock);
		#1 rxd_in = 1'b0;
		repeat (clks) @(posedge clock);
		for (int i = 0; i < nb; i++) begin
			#1 rxd_in = f[i];
			repeat (clks) @(posedge clock);
		end
		#1 rxd_in = 1'b1;
	endtask
endmodule

// >>> verification/test_uab_serial_port.sv
`timescale 1ns/100ps
`include "uab_defines.svh"
module test_uab_serial_port import uab_pkg::*;;
	logic clock;
	logic rst_b;
	uab_sfr_req_t req;
	logic [7:0] rdata;
	logic tbr, t1, smod, rxd_in, rxd_out, rxd_oe, txd, cpin, trig, sirq, airq;
	logic m0;
	logic [15:0] bclk;
	logic [3:0] nb;
	logic [31:0] seed;
	int n_mismatch, n_checks, cyc;
	logic [1:0] md[7] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h3};
	logic [7:0] ac[7] = '{8'h34, 8'h00, 8'h00, 8'h24, 8'h14, 8'h36, 8'h16};
	logic [15:0] rl[7] = '{16'hFFFE, 16'h0000, 16'h0000, 16'hFFFF,
		16'hFFFF, 16'hFFFF, 16'hFFFF};
	logic [6:0] sm = 7'h7B;
	uab_serial_port u_dut (.clock(clock), .rst_b(rst_b), .sfr_req(req),
		.sfr_rdata(rdata), .tx_buffer_ready(tbr), .timer1_ovf(t1),
		.smod(smod), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
		.txd(txd), .aux_count_pin(cpin), .aux_trigger_pin(trig),
		.serial_irq(sirq), .aux_irq(airq));
	uab_remote u_rem (.clock(clock), .m0(m0), .bit_clks(bclk), .nbits(nb),
		.txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in));
	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [10:0] exp_frame(logic [1:0] m, logic [7:0] d,
		logic n);
		if (m == 2'h1) return {2'b00, 1'b1, d};
		return {1'b0, 1'b1, n, d};
	endfunction
	function automatic logic [15:0] bits_for(logic [1:0] m, logic s, logic a,
		logic [15:0] r);
		if (m == 2'h2) return s ? 16'h20 : 16'h40;
		if (a) return 16'(32 * (65536 - int'(r)));
		return s ? 16'h10 : 16'h20;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		req.wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	// let the launching edge land before looking at the flag
	task automatic wait_irq(int lim);
		int k;
		k = 0;
		do begin
			@(posedge clock);
			#1 k++;
		end while (sirq !== 1'b1 && k < lim);
		chk("serial irq", 1, sirq);
	endtask
	task automatic pop_chk(logic [10:0] e);
		logic [10:0] g;
		g = 11'h7FF;
		if (u_rem.got_q.size() > 0) g = u_rem.got_q.pop_front();
		chk("line frame", e, g);
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		cpin <= ~cpin;
		t1 <= 1'b1;
		if (cyc == 60000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		logic [7:0] v;
		logic [7:0] d;
		logic n9;
		logic ok;
		logic [10:0] f;
		logic [7:0] q[$];
		int k;
		rst_b = 1'b0;
		req = '0;
		smod = 1'b1;
		t1 = 1'b0;
		cpin = 1'b1;
		trig = 1'b1;
		m0 = 1'b0;
		bclk = 16'h10;
		nb = 4'h9;
		seed = 32'hB796;
		n_mismatch = 0;
		n_checks = 0;
		cyc = 0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		rd(`UAB_A_SCTL, v);
		chk("sctl reset", `UAB_SCTL_RESET, v);
		rd(`UAB_A_ACTL, v);
		chk("actl reset", `UAB_ACTL_RESET, v);
		rd(8'h07, v);
		chk("unmapped", 0, v);
		wr(`UAB_A_SCTL, 8'hEC);
		rd(`UAB_A_SCTL, v);
		chk("sctl", 8'hEC, v);
		for (int c = 0; c < 7; c++) begin
			smod <= sm[c];
			wr(`UAB_A_ACTL, 8'h00);
			wr(`UAB_A_RLL, rl[c][7:0]);
			wr(`UAB_A_RLH, rl[c][15:8]);
			wr(`UAB_A_CNTL, rl[c][7:0]);
			wr(`UAB_A_CNTH, rl[c][15:8]);
			wr(`UAB_A_ACTL, ac[c]);
			seed = xs(seed);
			d = seed[7:0];
			n9 = seed[8];
			nb = (md[c] == 2'h1) ? 4'h9 : 4'hA;
			bclk = bits_for(md[c], sm[c], ac[c][4], rl[c]);
			wr(`UAB_A_SCTL, {md[c], 2'b01, n9, 3'b000});
			wr(`UAB_A_SERIAL_BUFFER, d);
			wait_irq(12 * bclk + 40);
			rd(`UAB_A_SCTL, v);
			chk("tx done", 1, v[1]);
			pop_chk(exp_frame(md[c], d, n9));
			wr(`UAB_A_SCTL, {md[c], 2'b01, n9, 3'b000});
			bclk = bits_for(md[c], sm[c], ac[c][5], rl[c]);
			f = exp_frame(md[c], seed[23:16], seed[9]);
			u_rem.send(f, nb, bclk);
			wait_irq(4 * bclk);
			rd(`UAB_A_SCTL, v);
			chk("rx ninth", f[8], v[2]);
			chk("rx done", 1, v[0]);
			rd(`UAB_A_SERIAL_BUFFER, v);
			chk("rx data", f[7:0], v);
		end
		wr(`UAB_A_ACTL, 8'h00);
		wr(`UAB_A_ACTL, 8'h3C);
		trig <= 1'b0;
		k = 0;
		do begin
			@(posedge clock);
			#1 k++;
		end while (airq !== 1'b1 && k < 20);
		chk("aux irq", 1, airq);
		rd(`UAB_A_ACTL, v);
		chk("actl", 8'h7C, v);
		trig <= 1'b1;
		wr(`UAB_A_ACTL, 8'h00);
		wr(`UAB_A_ACTL, 8'h34);
		wr(`UAB_A_SCTL, 8'hC0);
		bclk = 16'h20;
		nb = 4'hA;
		seed = xs(seed);
		@(posedge clock);
		req <= '{`UAB_A_SERIAL_BUFFER, seed[7:0], 1'b1, 1'b0};
		// the line drains slowly, so the buffer must refuse
		for (int i = 0; i < 14; i++) begin
			#5 ok = tbr;
			@(posedge clock);
			if (!ok) break;
			q.push_back(req.wdata);
			seed = xs(seed);
			req.wdata <= seed[7:0];
		end
		req.wr <= 1'b0;
		chk("buffer full", 0, ok);
		k = 0;
		while (u_rem.got_q.size() < q.size() && k < 6000) begin
			@(posedge clock);
			k++;
		end
		foreach (q[i]) pop_chk(exp_frame(2'h3, q[i], 1'b0));
		wr(`UAB_A_ACTL, 8'h00);
		// event counter on the count pin stays put until run is set
		wr(`UAB_A_RLL, 8'h00);
		wr(`UAB_A_RLH, 8'hAB);
		wr(`UAB_A_CNTL, 8'hF0);
		wr(`UAB_A_CNTH, 8'hFF);
		wr(`UAB_A_ACTL, 8'h02);
		repeat (40) @(posedge clock);
		rd(`UAB_A_CNTL, v);
		chk("count held", 8'hF0, v);
		wr(`UAB_A_ACTL, 8'h06);
		repeat (60) @(posedge clock);
		#1 chk("aux irq", 1, airq);
		wr(`UAB_A_ACTL, 8'h00);
		rd(`UAB_A_CNTH, v);
		chk("count reloaded", 8'hAB, v);
		m0 = 1'b1;
		wr(`UAB_A_SCTL, 8'h00);
		seed = xs(seed);
		wr(`UAB_A_SERIAL_BUFFER, seed[7:0]);
		wait_irq(200);
		chk("shift out", seed[7:0], u_rem.m0_in);
		chk("shift period", 0, u_rem.m0_bad);
		u_rem.m0_out = seed[15:8];
		wr(`UAB_A_SCTL, 8'h10);
		wait_irq(200);
		rd(`UAB_A_SERIAL_BUFFER, v);
		chk("shift in", seed[15:8], v);
		m0 = 1'b0;
		tally_and_finish();
	end
endmodule
